// ===== hdl/mhc_top.sv
// Modulator high carrier source selector, conditioner and switch gate
`timescale 1ns/1ps
`include "mhc_consts.svh"
module mhc_top
  import mhc_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk_sys_in,
  input  wire logic                     rst_n_in,
  // Register port
  input  wire logic [`MHC_ADDR_W-1:0]   reg_addr_in,
  input  wire logic [`MHC_DATA_W-1:0]   reg_wdata_in,
  input  wire logic                     reg_wr_in,
  input  wire logic                     reg_rd_in,
  output logic      [`MHC_DATA_W-1:0]   reg_rdata_out,
  // Carrier sources from outside the clock domain
  input  wire logic                     carrier_input_pin_one_in,
  input  wire logic                     carrier_input_pin_two_in,
  input  wire logic                     ref_clock_in,
  // Carrier sources from logic on this clock
  input  wire logic                     compare_pwm_unit_one_in,
  input  wire logic                     compare_pwm_unit_two_in,
  input  wire logic                     compare_pwm_unit_three_in,
  input  wire logic                     compare_pwm_unit_four_in,
  // Modulation request, high means use the high carrier
  input  wire logic                     mod_level_in,
  // Conditioned high carrier towards the modulator core
  output logic                          high_carrier_out,
  // Switch decision, high while the high carrier is in use
  output logic                          use_high_out,
  // Pin drive cut per source: refclock, then PWM one to four
  output logic      [`MHC_NUM_DRV-1:0]  drive_disable_out
);

  mhc_regs_s                st_q;      // Registered state
  mhc_regs_s                st_d;      // Next state
  logic [`MHC_NUM_SYNC-1:0] sync_lvl;  // Synchronised outside inputs
  logic [`MHC_NUM_SYNC-1:0] raw_vec;   // Raw outside inputs
  logic                     fall;      // Falling edge of the carrier
  logic                     reg_hit;   // Address decodes to our register

  // True for codes that connect nothing
  function automatic logic mhc_is_rsvd(input logic [`MHC_SEL_W-1:0] sel);
    mhc_is_rsvd = sel[`MHC_RSVD_BIT];
  endfunction

  // Drive index for a code, valid only for drivable sources
  function automatic logic [`MHC_NUM_DRV-1:0] mhc_drv_onehot(input logic [`MHC_SEL_W-1:0] sel);
    logic [`MHC_NUM_DRV-1:0] v;
    v = '0;
    case (sel)
      `MHC_CODE_REFCLK: v[0] = 1'b1;
      `MHC_CODE_PWM1:   v[1] = 1'b1;
      `MHC_CODE_PWM2:   v[2] = 1'b1;
      `MHC_CODE_PWM3:   v[3] = 1'b1;
      `MHC_CODE_PWM4:   v[4] = 1'b1;
      default:          v    = '0;
    endcase
    mhc_drv_onehot = v;
  endfunction

  // Outside inputs gathered for the synchroniser
  assign raw_vec[`MHC_SYN_PIN1]   = carrier_input_pin_one_in;
  assign raw_vec[`MHC_SYN_PIN2]   = carrier_input_pin_two_in;
  assign raw_vec[`MHC_SYN_REFCLK] = ref_clock_in;

  // Three-stage synchroniser for pins and reference clock
  mhc_sync u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .raw_in     (raw_vec),
    .level_out  (sync_lvl)
  );

  // Decode of the register address
  assign reg_hit = (reg_addr_in == `MHC_ADDR_HCAR);

  // Falling edge seen on the registered carrier
  assign fall = st_q.car_prev & ~st_q.car;

  // Next-state logic
  always_comb
  begin
    logic sel_car;  // Carrier before polarity
    logic want_low; // Modulator asks for the low carrier
    st_d     = st_q;
    sel_car  = 1'b0;
    want_low = ~mod_level_in;

    // Register write
    if (reg_wr_in && reg_hit)
    begin
      st_d.sel  = reg_wdata_in[`MHC_SEL_MSB:`MHC_SEL_LSB];
      st_d.sync = reg_wdata_in[`MHC_SYNC_BIT];
      st_d.inv  = reg_wdata_in[`MHC_INV_BIT];
      st_d.dis  = reg_wdata_in[`MHC_DIS_BIT];
    end

    // Read data stand only in the cycle after the strobe
    st_d.rdata = `MHC_RST_DATA;
    if (reg_rd_in && reg_hit)
    begin
      st_d.rdata[`MHC_SEL_MSB:`MHC_SEL_LSB] = st_q.sel;
      st_d.rdata[`MHC_SPARE_BIT]           = 1'b0;
      st_d.rdata[`MHC_SYNC_BIT]            = st_q.sync;
      st_d.rdata[`MHC_INV_BIT]             = st_q.inv;
      st_d.rdata[`MHC_DIS_BIT]             = st_q.dis;
    end

    case (st_q.sel)
      `MHC_CODE_VSS:    sel_car = 1'b0;
      `MHC_CODE_PIN1:   sel_car = sync_lvl[`MHC_SYN_PIN1];
      `MHC_CODE_PIN2:   sel_car = sync_lvl[`MHC_SYN_PIN2];
      `MHC_CODE_REFCLK: sel_car = sync_lvl[`MHC_SYN_REFCLK];
      `MHC_CODE_PWM1:   sel_car = compare_pwm_unit_one_in;
      `MHC_CODE_PWM2:   sel_car = compare_pwm_unit_two_in;
      `MHC_CODE_PWM3:   sel_car = compare_pwm_unit_three_in;
      `MHC_CODE_PWM4:   sel_car = compare_pwm_unit_four_in;
      default:          sel_car = 1'b0;
    endcase

    if (mhc_is_rsvd(st_q.sel))
    begin
      st_d.car = 1'b0;
    end
    else
    begin
      st_d.car = sel_car ^ st_q.inv;
    end
    st_d.car_prev = st_q.car;

    case (st_q.fsm)
      MHC_ST_HIGH:
      begin
        // Leave the high carrier when asked
        if (want_low)
        begin
          if (st_q.sync && !fall)
          begin
            st_d.fsm = MHC_ST_WAIT;
          end
          else
          begin
            st_d.fsm = MHC_ST_LOW;
          end
        end
      end
      MHC_ST_WAIT:
      begin
        // Request withdrawn, sync cleared or edge seen
        if (!want_low)
        begin
          st_d.fsm = MHC_ST_HIGH;
        end
        else if (!st_q.sync || fall)
        begin
          st_d.fsm = MHC_ST_LOW;
        end
      end
      MHC_ST_LOW:
      begin
        // Back to high at once; low side sync is elsewhere
        if (!want_low)
        begin
          st_d.fsm = MHC_ST_HIGH;
        end
      end
      default:
      begin
        st_d.fsm = MHC_ST_HIGH;
      end
    endcase
    st_d.use_high = (st_d.fsm != MHC_ST_LOW);

    // pin drive cut for the selected source
    if (st_q.dis && !mhc_is_rsvd(st_q.sel))
    begin
      st_d.drv_dis = mhc_drv_onehot(st_q.sel);
    end
    else
    begin
      st_d.drv_dis = '0;
    end
  end

  // State register
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_q.sel      <= `MHC_RST_SEL;
      st_q.sync     <= `MHC_RST_BIT;
      st_q.inv      <= `MHC_RST_BIT;
      st_q.dis      <= `MHC_RST_BIT;
      st_q.rdata    <= `MHC_RST_DATA;
      st_q.car      <= 1'b0;
      st_q.car_prev <= 1'b0;
      st_q.fsm      <= MHC_ST_HIGH;
      st_q.use_high <= 1'b1;
      st_q.drv_dis  <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata_out     = st_q.rdata;
  assign high_carrier_out  = st_q.car;
  assign use_high_out      = st_q.use_high;
  assign drive_disable_out = st_q.drv_dis;

  a_sel_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (reg_wr_in && reg_hit) |=> (st_q.sel == $past(reg_wdata_in[`MHC_SEL_MSB:`MHC_SEL_LSB])))
    else $error("selection field not written");

  a_pwm_route: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (st_q.sel == `MHC_CODE_PWM1) |=> (high_carrier_out == $past(compare_pwm_unit_one_in ^ st_q.inv)))
    else $error("PWM one not routed");

  a_rsvd_quiet: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (st_q.sel[`MHC_RSVD_BIT] ##1 st_q.sel[`MHC_RSVD_BIT]) |=> (!high_carrier_out && drive_disable_out == '0))
    else $error("reserved code connected a source");

  a_pol_invert: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (st_q.sel == `MHC_CODE_VSS) |=> (high_carrier_out == $past(st_q.inv)))
    else $error("polarity not applied");

  a_sync_wait: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (st_q.sync && st_q.fsm == MHC_ST_HIGH && !mod_level_in && !fall) |=> use_high_out)
    else $error("switch did not wait for falling edge");

  a_sync_release: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (use_high_out && !mod_level_in && fall) |=> !use_high_out)
    else $error("falling edge did not release switch");

  a_nosync_switch: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (!st_q.sync && !mod_level_in) |=> !use_high_out)
    else $error("unsynchronised switch delayed");

  a_drive_cut: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (st_q.dis && st_q.sel == `MHC_CODE_PWM2) |=> (drive_disable_out == 5'h04))
    else $error("pin drive not cut");

  a_pin_route: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (st_q.sel == `MHC_CODE_PIN1) |=> (high_carrier_out == $past(sync_lvl[`MHC_SYN_PIN1] ^ st_q.inv)))
    else $error("pin one not routed");

  a_pin_two_route: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (st_q.sel == `MHC_CODE_PIN2) |=> (high_carrier_out == $past(sync_lvl[`MHC_SYN_PIN2] ^ st_q.inv)))
    else $error("pin two not routed");

  a_pwm_four_route: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (st_q.sel == `MHC_CODE_PWM4) |=> (high_carrier_out == $past(compare_pwm_unit_four_in ^ st_q.inv)))
    else $error("PWM four not routed");

  a_read_field: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (reg_rd_in && reg_hit) |=>
      (reg_rdata_out[`MHC_SEL_MSB:`MHC_SEL_LSB] == $past(st_q.sel) && !reg_rdata_out[`MHC_SPARE_BIT]))
    else $error("read data do not match the field");

  a_read_idle: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !(reg_rd_in && reg_hit) |=> (reg_rdata_out == `MHC_RST_DATA))
    else $error("read data outside the read cycle");

  a_wait_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (st_q.sync && st_q.fsm == MHC_ST_WAIT && !mod_level_in && !fall) |=> use_high_out)
    else $error("wait left without falling edge");

  a_return_high: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    mod_level_in |=> use_high_out)
    else $error("high carrier not resumed");

  a_drive_keep: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !st_q.dis |=> (drive_disable_out == '0))
    else $error("pin drive cut while enabled");

endmodule

// ===== hdl/mhc_consts.svh
// Constants for the modulator high carrier selector
`ifndef MHC_CONSTS_SVH
`define MHC_CONSTS_SVH
// Register port widths
`define MHC_ADDR_W      4
`define MHC_DATA_W      8
// Register address of the high carrier control word
`define MHC_ADDR_HCAR   4'h0
// Field positions inside the control word
`define MHC_SEL_MSB     3
`define MHC_SEL_LSB     0
`define MHC_SPARE_BIT   4
`define MHC_SYNC_BIT    5
`define MHC_INV_BIT     6
`define MHC_DIS_BIT     7
// Field widths and reset values
`define MHC_SEL_W       4
`define MHC_RST_SEL     4'h0
`define MHC_RST_BIT     1'h0
`define MHC_RST_DATA    8'h00
// Source selection codes
`define MHC_CODE_VSS    4'h0
`define MHC_CODE_PIN1   4'h1
`define MHC_CODE_PIN2   4'h2
`define MHC_CODE_REFCLK 4'h3
`define MHC_CODE_PWM1   4'h4
`define MHC_CODE_PWM2   4'h5
`define MHC_CODE_PWM3   4'h6
`define MHC_CODE_PWM4   4'h7
// Top bit of the code marks the reserved half
`define MHC_RSVD_BIT    3
// Number of synchronised inputs and of drivable sources
`define MHC_NUM_SYNC    3
`define MHC_NUM_DRV     5
// Index of each synchronised input
`define MHC_SYN_PIN1    0
`define MHC_SYN_PIN2    1
`define MHC_SYN_REFCLK  2
`endif

// ===== hdl/mhc_pkg.sv
// Types shared by the modulator high carrier selector
`include "mhc_consts.svh"
package mhc_pkg;
  // Switch tracking states, one-hot
  typedef enum logic [2:0] {
    MHC_ST_HIGH = 3'b001,
    MHC_ST_WAIT = 3'b010,
    MHC_ST_LOW  = 3'b100
  } mhc_state_e;

  // State of the top module
  typedef struct packed {
    logic [`MHC_SEL_W-1:0]   sel;
    logic                    sync;
    logic                    inv;
    logic                    dis;
    logic [`MHC_DATA_W-1:0]  rdata;
    logic                    car;
    logic                    car_prev;
    mhc_state_e              fsm;
    logic                    use_high;
    logic [`MHC_NUM_DRV-1:0] drv_dis;
  } mhc_regs_s;

  // State of the input synchroniser
  typedef struct packed {
    logic [`MHC_NUM_SYNC-1:0] s1;
    logic [`MHC_NUM_SYNC-1:0] s2;
    logic [`MHC_NUM_SYNC-1:0] s3;
    logic [`MHC_NUM_SYNC-1:0] q;
  } mhc_sync_s;
endpackage

// ===== hdl/mhc_sync.sv
// Three-stage synchroniser with agreement filter for outside inputs
`timescale 1ns/1ps
`include "mhc_consts.svh"
module mhc_sync
  import mhc_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk_sys_in,
  input  wire logic                     rst_n_in,
  // Raw inputs from outside the clock domain
  input  wire logic [`MHC_NUM_SYNC-1:0] raw_in,
  // Filtered synchronous levels
  output logic      [`MHC_NUM_SYNC-1:0] level_out
);

  mhc_sync_s st_q;  // Registered state
  mhc_sync_s st_d;  // Next state

  // Shift chain; the level moves only when stages two and three agree
  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = raw_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < `MHC_NUM_SYNC; i++)
    begin
      // Agreement of the later stages
      if (st_q.s2[i] == st_q.s3[i])
      begin
        st_d.q[i] = st_q.s3[i];
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.q;

endmodule

// ===== verification/modulator_high_carrier_select_test.sv
// Self-checking bench for the modulator high carrier selector
`timescale 1ns/1ps
`include "mhc_consts.svh"
module modulator_high_carrier_select_test
  import mhc_pkg::*;
;
  // Clock, reset and register port
  logic       clk_sys_in;
  logic       rst_n_in;
  logic [3:0] reg_addr_in;
  logic [7:0] reg_wdata_in;
  logic       reg_wr_in;
  logic       reg_rd_in;
  logic [7:0] reg_rdata_out;
  // Carrier sources, packed pwm4..pwm1, refclock, pin two, pin one
  logic [6:0] src_in;
  logic       mod_level_in;
  // Outputs under test
  logic       high_carrier_out;
  logic       use_high_out;
  logic [4:0] drive_disable_out;
  // Notes of expected results and checker bookkeeping
  logic [7:0] rd_q[$];
  logic [6:0] out_q[$];
  logic       rd_seen;
  logic       chk_tog;
  logic       tog_seen;
  int         err_count;
  int         num_checks;

  mhc_top dut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .carrier_input_pin_one_in(src_in[0]),
    .carrier_input_pin_two_in(src_in[1]), .ref_clock_in(src_in[2]),
    .compare_pwm_unit_one_in(src_in[3]), .compare_pwm_unit_two_in(src_in[4]),
    .compare_pwm_unit_three_in(src_in[5]), .compare_pwm_unit_four_in(src_in[6]),
    .mod_level_in(mod_level_in), .high_carrier_out(high_carrier_out),
    .use_high_out(use_high_out), .drive_disable_out(drive_disable_out)
  );

  // 50 MHz clock
  initial clk_sys_in = 1'b0;
  always #10 clk_sys_in = ~clk_sys_in;

  // Compare read data
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compare carrier, switch and drive cut outputs
  task automatic cmp_out(input logic [6:0] got, input logic [6:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Print counts and verdict, then stop
  task automatic conclude;
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // One-cycle register write
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in    <= 1'b0;
  endtask

  // One-cycle register read, expected data noted first
  task automatic reg_read(input logic [3:0] a, input logic [7:0] exp);
    rd_q.push_back(exp);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in   <= 1'b0;
  endtask

  // Note expected outputs for the current cycle
  task automatic check_out(input logic hc, input logic uh, input logic [4:0] dd);
    out_q.push_back({hc, uh, dd});
    chk_tog <= ~chk_tog;
    @(posedge clk_sys_in);
  endtask

  // Watcher: read data in the cycle after a strobe, zero otherwise
  always @(posedge clk_sys_in)
  begin
    if (rd_seen)
      cmp_byte(reg_rdata_out, rd_q.pop_front());
    else
      cmp_byte(reg_rdata_out, 8'h00);
    if (tog_seen !== chk_tog)
      cmp_out({high_carrier_out, use_high_out, drive_disable_out}, out_q.pop_front());
    rd_seen  <= reg_rd_in;
    tog_seen <= chk_tog;
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    err_count++;
    conclude();
  end

  // Main sequence
  initial
  begin : main_seq
    logic [7:0] d;
    logic [7:0] vec;
    logic [3:0] sel;
    logic       inv;
    logic       dis;
    logic [4:0] exp_dd;
    err_count = 0;
    num_checks = 0;
    rst_n_in = 1'b0;
    reg_addr_in = 4'h0;
    reg_wdata_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    src_in = 7'h00;
    mod_level_in = 1'b1;
    rd_seen = 1'b0;
    chk_tog = 1'b0;
    tog_seen = 1'b0;
    void'($urandom(32'h242D6C21));
    repeat (8) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    // Reset state
    reg_read(`MHC_ADDR_HCAR, 8'h00);
    check_out(1'b0, 1'b1, 5'h00);
    // Register access, spare bit and unmapped addresses
    repeat (8)
    begin
      d = 8'($urandom);
      sel = 4'h1 + 4'($urandom % 15);
      reg_write(`MHC_ADDR_HCAR, d);
      reg_read(`MHC_ADDR_HCAR, d & 8'hEF);
      reg_write(sel, ~d);
      reg_read(sel, 8'h00);
    end
    // Every code with and without inversion, random sources and drive cut
    for (int c = 0; c < 32; c++)
    begin
      sel = 4'(c);
      inv = c[4];
      // Each code meets the drive cut once, in one of its two passes
      dis = c[0] ^ c[4];
      src_in <= 7'($urandom);
      reg_write(`MHC_ADDR_HCAR, {dis, inv, 2'b00, sel});
      repeat (6) @(posedge clk_sys_in);
      vec = {src_in, 1'b0};
      exp_dd = (dis && sel >= 4'h3 && sel <= 4'h7) ? 5'h01 << (sel - 4'h3) : 5'h00;
      check_out(sel[3] ? 1'b0 : vec[sel[2:0]] ^ inv, 1'b1, exp_dd);
      reg_read(`MHC_ADDR_HCAR, {dis, inv, 2'b00, sel});
    end
    // Switch without synchronisation follows the request at once
    src_in <= 7'h08;
    reg_write(`MHC_ADDR_HCAR, 8'h04);
    repeat (3) @(posedge clk_sys_in);
    mod_level_in <= 1'b0;
    check_out(1'b1, 1'b1, 5'h00);
    check_out(1'b1, 1'b0, 5'h00);
    mod_level_in <= 1'b1;
    check_out(1'b1, 1'b0, 5'h00);
    check_out(1'b1, 1'b1, 5'h00);
    // Synchronised switch waits for a falling edge of the adjusted carrier
    for (int i = 0; i < 2; i++)
    begin
      inv = i[0];
      src_in <= {3'h0, ~inv, 3'h0};
      reg_write(`MHC_ADDR_HCAR, {1'b0, inv, 2'b10, 4'h4});
      repeat (3) @(posedge clk_sys_in);
      mod_level_in <= 1'b0;
      repeat (3) check_out(1'b1, 1'b1, 5'h00);
      src_in <= {3'h0, inv, 3'h0};
      check_out(1'b1, 1'b1, 5'h00);
      check_out(1'b0, 1'b1, 5'h00);
      check_out(1'b0, 1'b0, 5'h00);
      mod_level_in <= 1'b1;
      check_out(1'b0, 1'b0, 5'h00);
      check_out(1'b0, 1'b1, 5'h00);
    end
    // Clearing the sync bit while waiting releases the switch
    src_in <= 7'h08;
    reg_write(`MHC_ADDR_HCAR, 8'h24);
    repeat (3) @(posedge clk_sys_in);
    mod_level_in <= 1'b0;
    repeat (2) check_out(1'b1, 1'b1, 5'h00);
    reg_write(`MHC_ADDR_HCAR, 8'h04);
    repeat (2) @(posedge clk_sys_in);
    check_out(1'b1, 1'b0, 5'h00);
    repeat (4) @(posedge clk_sys_in);
    conclude();
  end
endmodule
